/* File: hdpc_map.vh */
// register map, field positions, reset values and timing constants
`ifndef HDPC_MAP_VH
`define HDPC_MAP_VH
// ==========================================
// register offsets
`define HDPC_OFF_ERROR 8'h02
`define HDPC_OFF_SYSCTL2 8'h05
`define HDPC_OFF_HP_VOL 8'h0C
`define HDPC_OFF_DC_CFG 8'h0F
`define HDPC_OFF_L1_SOFT 8'h3B
`define HDPC_OFF_L1_AR 8'h3C
`define HDPC_OFF_L2_SOFT 8'h3E
`define HDPC_OFF_L2_AR 8'h3F
`define HDPC_OFF_L1_THR 8'h40
`define HDPC_OFF_L2_THR 8'h43
`define HDPC_OFF_FEATURE 8'h46
`define HDPC_OFF_SCALE 8'h56
`define HDPC_OFF_CLIP 8'h57
`define HDPC_OFF_CHKSUM 8'h60
// ==========================================
// field positions
`define HDPC_SC2_HP_USED 0
`define HDPC_SC2_PIN_OE 1
`define HDPC_SC2_HP_VOLSEL 3
`define HDPC_SC2_HP_MODE 4
`define HDPC_SC2_SHUTDOWN 6
`define HDPC_FE_LIM_EN 0
`define HDPC_FE_TWO_BAND 1
`define HDPC_FE_DC_EN 10
`define HDPC_FE_CRC_EN 25
`define HDPC_ERR_DC 0
`define HDPC_ERR_CRC 3
// ==========================================
// reset values
`define HDPC_RST_SYSCTL2 8'h40
`define HDPC_RST_CLIP 32'h007FFFFF
`define HDPC_RST_SCALE 32'h00800000
`define HDPC_UNITY_GAIN 26'h0800000
`define HDPC_ZERO32 32'h00000000
// ==========================================
// timing and sizes
`define HDPC_CLK_NS 8
`define HDPC_SETTLE_NS 1000000
`define HDPC_SETTLE_CYC ((`HDPC_SETTLE_NS + `HDPC_CLK_NS - 1) / `HDPC_CLK_NS)
`define HDPC_COEF_WORDS 7'h50
`define HDPC_COEF_LAST 7'h4F
`endif

/* File: hdpc_dc_detect.v */
// pwm dc-duty detector with threshold and duration
`timescale 1ns/1ns
module hdpc_dc_detect (
  input wire sys_clk,
  input wire rst,
  input wire enable,
  input wire duty_tick,
  input wire [7:0] duty,
  input wire [3:0] threshold,
  input wire [3:0] duration,
  output reg dc_error_r
);
  reg [4:0] run_r;
  wire over;

  // ==========================================
  // duty over threshold, compared on upper nibble
  assign over = (duty[7:4] > threshold);

  // count ticks above threshold; flag follows the condition
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_r <= 5'h00;
      dc_error_r <= 1'b0;
    end else if (!enable) begin
      run_r <= 5'h00;
      dc_error_r <= 1'b0;
    end else if (duty_tick) begin
      if (over) begin
        if (run_r <= {1'b0, duration}) begin
          run_r <= run_r + 5'h01;
        end
        dc_error_r <= (run_r >= {1'b0, duration});
      end else begin
        run_r <= 5'h00;
        dc_error_r <= 1'b0;
      end
    end
  end
endmodule

/* File: hdpc_limiter.v */
// one gain limiter: hold timers then attack or release steps
`timescale 1ns/1ns
`include "hdpc_map.vh"
module hdpc_limiter (
  input wire sys_clk,
  input wire rst,
  input wire enable,
  input wire sample_tick,
  input wire [31:0] level,
  input wire [31:0] threshold,
  input wire [7:0] attack_hold,
  input wire [7:0] release_hold,
  input wire [25:0] step,
  output reg [25:0] gain_r
);
  reg [7:0] above_r;
  reg [7:0] below_r;
  wire is_above;
  wire [26:0] up_sum;

  // ==========================================
  // level and threshold both 9.23 signed
  assign is_above = ($signed(level) > $signed(threshold));
  assign up_sum = {1'b0, gain_r} + {1'b0, step};

  // a direction must persist for its whole hold time before gain moves
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      above_r <= 8'h00;
      below_r <= 8'h00;
      gain_r <= `HDPC_UNITY_GAIN;
    end else if (!enable) begin
      above_r <= 8'h00;
      below_r <= 8'h00;
      gain_r <= `HDPC_UNITY_GAIN;
    end else if (sample_tick) begin
      if (is_above) begin
        below_r <= 8'h00;
        if (above_r < attack_hold) begin
          above_r <= above_r + 8'h01;
        end else if (gain_r > step) begin
          gain_r <= gain_r - step;
        end else begin
          gain_r <= 26'h0000000;
        end
      end else begin
        above_r <= 8'h00;
        if (below_r < release_hold) begin
          below_r <= below_r + 8'h01;
        end else if (up_sum[25:0] >= `HDPC_UNITY_GAIN || up_sum[26]) begin
          gain_r <= `HDPC_UNITY_GAIN;
        end else begin
          gain_r <= up_sum[25:0];
        end
      end
    end
  end
endmodule

/* File: hdpc_top.v */
// audio protection, headphone control, clip/scale and limiter control
`timescale 1ns/1ns
`include "hdpc_map.vh"
module hdpc_top #(
  parameter integer SETTLE_CYC = `HDPC_SETTLE_CYC
) (
  input wire sys_clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_r,
  output reg reg_rvalid_r,
  input wire addr_select_hp_shutdown_pin_i,
  output reg addr_select_hp_shutdown_pin_o_r,
  output reg addr_select_hp_shutdown_pin_oe_r,
  output reg addr_select_r,
  input wire overcurrent_i,
  input wire overtemp_i,
  input wire undervoltage_i,
  input wire [7:0] spk_volume,
  output reg [7:0] hp_gain_r,
  output reg pwm_run_r,
  output reg spk_mute_r,
  output reg hp_pwm_en_r,
  input wire sample_valid,
  input wire [23:0] sample_l,
  input wire [23:0] sample_r,
  output reg sample_out_valid_r,
  output reg [23:0] sample_out_l_r,
  output reg [23:0] sample_out_r_r,
  input wire duty_tick,
  input wire [7:0] duty,
  input wire [31:0] band_hi_level,
  input wire [31:0] band_lo_level,
  output wire [25:0] upper_band_gain,
  output wire [25:0] lower_band_gain,
  output reg [6:0] coef_rd_addr_r,
  input wire [31:0] coef_rd_data
);
  // ==========================================
  // registers
  reg [7:0] sysctl2_r;
  reg [7:0] hp_vol_r;
  reg [7:0] dc_cfg_r;
  reg [31:0] l1_soft_r;
  reg [31:0] l1_ar_r;
  reg [31:0] l2_soft_r;
  reg [31:0] l2_ar_r;
  reg [31:0] l1_thr_r;
  reg [31:0] l2_thr_r;
  reg [31:0] feature_r;
  reg [31:0] scale_r;
  reg [31:0] clip_r;
  reg [31:0] chksum_r;
  reg crc_err_r;
  wire dc_err;
  reg [31:0] rd_nxt;

  // software writes; error register has no write path
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sysctl2_r <= `HDPC_RST_SYSCTL2;
      hp_vol_r <= 8'h00;
      dc_cfg_r <= 8'h00;
      l1_soft_r <= `HDPC_ZERO32;
      l1_ar_r <= `HDPC_ZERO32;
      l2_soft_r <= `HDPC_ZERO32;
      l2_ar_r <= `HDPC_ZERO32;
      l1_thr_r <= `HDPC_ZERO32;
      l2_thr_r <= `HDPC_ZERO32;
      feature_r <= `HDPC_ZERO32;
      scale_r <= `HDPC_RST_SCALE;
      clip_r <= `HDPC_RST_CLIP;
      chksum_r <= `HDPC_ZERO32;
    end else if (reg_wr) begin
      case (reg_addr)
        `HDPC_OFF_SYSCTL2: sysctl2_r <= reg_wdata[7:0];
        `HDPC_OFF_HP_VOL: hp_vol_r <= reg_wdata[7:0];
        `HDPC_OFF_DC_CFG: dc_cfg_r <= reg_wdata[7:0];
        `HDPC_OFF_L1_SOFT: l1_soft_r <= reg_wdata;
        `HDPC_OFF_L1_AR: l1_ar_r <= reg_wdata;
        `HDPC_OFF_L2_SOFT: l2_soft_r <= reg_wdata;
        `HDPC_OFF_L2_AR: l2_ar_r <= reg_wdata;
        `HDPC_OFF_L1_THR: l1_thr_r <= reg_wdata;
        `HDPC_OFF_L2_THR: l2_thr_r <= reg_wdata;
        `HDPC_OFF_FEATURE: feature_r <= reg_wdata;
        `HDPC_OFF_SCALE: scale_r <= reg_wdata;
        `HDPC_OFF_CLIP: clip_r <= reg_wdata;
        `HDPC_OFF_CHKSUM: chksum_r <= reg_wdata;
        default: chksum_r <= chksum_r;
      endcase
    end
  end

  // read mux; narrow registers in low bits, unmapped reads zero
  always @* begin
    case (reg_addr)
      `HDPC_OFF_ERROR: begin
        rd_nxt = `HDPC_ZERO32;
        rd_nxt[`HDPC_ERR_DC] = dc_err;
        rd_nxt[`HDPC_ERR_CRC] = crc_err_r;
      end
      `HDPC_OFF_SYSCTL2: rd_nxt = {24'h000000, sysctl2_r};
      `HDPC_OFF_HP_VOL: rd_nxt = {24'h000000, hp_vol_r};
      `HDPC_OFF_DC_CFG: rd_nxt = {24'h000000, dc_cfg_r};
      `HDPC_OFF_L1_SOFT: rd_nxt = l1_soft_r;
      `HDPC_OFF_L1_AR: rd_nxt = l1_ar_r;
      `HDPC_OFF_L2_SOFT: rd_nxt = l2_soft_r;
      `HDPC_OFF_L2_AR: rd_nxt = l2_ar_r;
      `HDPC_OFF_L1_THR: rd_nxt = l1_thr_r;
      `HDPC_OFF_L2_THR: rd_nxt = l2_thr_r;
      `HDPC_OFF_FEATURE: rd_nxt = feature_r;
      `HDPC_OFF_SCALE: rd_nxt = scale_r;
      `HDPC_OFF_CLIP: rd_nxt = clip_r;
      `HDPC_OFF_CHKSUM: rd_nxt = chksum_r;
      default: rd_nxt = `HDPC_ZERO32;
    endcase
  end

  // read data registered, one cycle after the strobe
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= `HDPC_ZERO32;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rd_nxt;
      end
    end
  end

  // ==========================================
  // pin synchronisers and address strap
  reg [1:0] pin_sync_r;
  reg [2:0] flt_s1_r;
  reg [2:0] flt_s2_r;
  reg strap_done_r;
  wire fault_n;

  // strap sync runs through reset, so the level is settled at the first edge after release
  always @(posedge sys_clk) begin
    pin_sync_r <= {pin_sync_r[0], addr_select_hp_shutdown_pin_i};
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flt_s1_r <= 3'b000;
      flt_s2_r <= 3'b000;
    end else begin
      flt_s1_r <= {overcurrent_i, overtemp_i, undervoltage_i};
      flt_s2_r <= flt_s1_r;
    end
  end

  // strap caught once after release, while the pin is still an input
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_done_r <= 1'b0;
      addr_select_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      addr_select_r <= pin_sync_r[1];
    end
  end

  assign fault_n = ~(|flt_s2_r);

  // ==========================================
  // shutdown sequencer: pwm runs before headphone enable, stops after it
  localparam ST_OFF = 2'b00;
  localparam ST_START = 2'b01;
  localparam ST_ON = 2'b10;
  localparam ST_STOP = 2'b11;
  reg [1:0] st_r;
  reg [16:0] cnt_r;
  reg hp_sd_n_r;
  wire shut;
  wire hp_mode;
  wire cnt_done;

  assign shut = sysctl2_r[`HDPC_SC2_SHUTDOWN];
  assign hp_mode = sysctl2_r[`HDPC_SC2_HP_MODE];
  assign cnt_done = ({15'h0000, cnt_r} >= SETTLE_CYC - 1);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_OFF;
      cnt_r <= 17'h00000;
      pwm_run_r <= 1'b0;
      hp_sd_n_r <= 1'b0;
    end else begin
      case (st_r)
        ST_OFF: begin
          hp_sd_n_r <= 1'b0;
          cnt_r <= 17'h00000;
          if (!shut) begin
            pwm_run_r <= 1'b1;
            st_r <= ST_START;
          end
        end
        ST_START: begin
          cnt_r <= cnt_r + 17'h00001;
          if (shut) begin
            cnt_r <= 17'h00000;
            st_r <= ST_STOP;
          end else if (cnt_done) begin
            hp_sd_n_r <= hp_mode;
            st_r <= ST_ON;
          end
        end
        ST_ON: begin
          hp_sd_n_r <= hp_mode;
          cnt_r <= 17'h00000;
          if (shut) begin
            hp_sd_n_r <= 1'b0;
            st_r <= ST_STOP;
          end
        end
        default: begin
          hp_sd_n_r <= 1'b0;
          cnt_r <= cnt_r + 17'h00001;
          if (cnt_done) begin
            pwm_run_r <= 1'b0;
            st_r <= ST_OFF;
          end
        end
      endcase
    end
  end

  // pin drive, mode outputs and headphone gain source
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_select_hp_shutdown_pin_oe_r <= 1'b0;
      addr_select_hp_shutdown_pin_o_r <= 1'b0;
      spk_mute_r <= 1'b1;
      hp_pwm_en_r <= 1'b0;
      hp_gain_r <= 8'h00;
    end else begin
      addr_select_hp_shutdown_pin_oe_r <= sysctl2_r[`HDPC_SC2_PIN_OE];
      if (sysctl2_r[`HDPC_SC2_HP_USED]) begin
        addr_select_hp_shutdown_pin_o_r <= hp_sd_n_r;
      end else begin
        addr_select_hp_shutdown_pin_o_r <= fault_n;
      end
      spk_mute_r <= hp_mode | ~pwm_run_r;
      hp_pwm_en_r <= hp_mode & pwm_run_r;
      hp_gain_r <= sysctl2_r[`HDPC_SC2_HP_VOLSEL] ? hp_vol_r : spk_volume;
    end
  end

  // ==========================================
  // clip then scale, both channels alike
  wire [47:0] smp_in;
  wire [47:0] smp_out;
  wire signed [23:0] clip_pos;
  wire signed [23:0] clip_neg;

  assign smp_in = {sample_l, sample_r};
  assign clip_pos = clip_r[23:0];
  assign clip_neg = -clip_r[23:0];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire signed [23:0] s;
      wire signed [23:0] c;
      wire signed [49:0] p;
      assign s = smp_in[ch*24 +: 24];
      assign c = (s > clip_pos) ? clip_pos : ((s < clip_neg) ? clip_neg : s);
      assign p = c * $signed(scale_r[25:0]);
      // saturate rather than wrap when scale exceeds unity
      assign smp_out[ch*24 +: 24] = (p[49:46] == {4{p[49]}}) ? p[46:23] :
        (p[49] ? 24'h800000 : 24'h7FFFFF);
    end
  endgenerate

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_out_valid_r <= 1'b0;
      sample_out_l_r <= 24'h000000;
      sample_out_r_r <= 24'h000000;
    end else begin
      sample_out_valid_r <= sample_valid;
      if (sample_valid) begin
        sample_out_r_r <= smp_out[23:0];
        sample_out_l_r <= smp_out[47:24];
      end
    end
  end

  // ==========================================
  // dc-duty detector
  hdpc_dc_detect u_dc (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(feature_r[`HDPC_FE_DC_EN]),
    .duty_tick(duty_tick),
    .duty(duty),
    .threshold(dc_cfg_r[7:4]),
    .duration(dc_cfg_r[3:0]),
    .dc_error_r(dc_err)
  );

  // ==========================================
  // coefficient checksum: rotate-xor over the biquad words, repeated
  reg [31:0] acc_r;
  reg rd_pend_r;
  reg last_pend_r;
  wire crc_en;

  assign crc_en = feature_r[`HDPC_FE_CRC_EN];

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      coef_rd_addr_r <= 7'h00;
      acc_r <= `HDPC_ZERO32;
      rd_pend_r <= 1'b0;
      last_pend_r <= 1'b0;
      crc_err_r <= 1'b0;
    end else if (!crc_en) begin
      coef_rd_addr_r <= 7'h00;
      acc_r <= `HDPC_ZERO32;
      rd_pend_r <= 1'b0;
      last_pend_r <= 1'b0;
      crc_err_r <= 1'b0;
    end else begin
      rd_pend_r <= 1'b1;
      last_pend_r <= (coef_rd_addr_r == `HDPC_COEF_LAST);
      coef_rd_addr_r <= (coef_rd_addr_r == `HDPC_COEF_LAST) ? 7'h00 :
        coef_rd_addr_r + 7'h01;
      if (rd_pend_r) begin
        if (last_pend_r) begin
          // pass complete: compare, then start the next pass
          crc_err_r <= ({acc_r[30:0], acc_r[31]} ^ coef_rd_data) != chksum_r;
          acc_r <= `HDPC_ZERO32;
        end else begin
          acc_r <= {acc_r[30:0], acc_r[31]} ^ coef_rd_data;
        end
      end
    end
  end

  // ==========================================
  // two limiters; lower band idles at unity in one-band mode
  wire [63:0] lim_level;
  wire [63:0] lim_thr;
  wire [63:0] lim_ar;
  wire [63:0] lim_soft;
  wire [1:0] lim_en;
  wire [51:0] lim_gain;

  assign lim_level = {band_lo_level, band_hi_level};
  assign lim_thr = {l2_thr_r, l1_thr_r};
  assign lim_ar = {l2_ar_r, l1_ar_r};
  assign lim_soft = {l2_soft_r, l1_soft_r};
  assign lim_en[0] = feature_r[`HDPC_FE_LIM_EN];
  assign lim_en[1] = feature_r[`HDPC_FE_LIM_EN] & feature_r[`HDPC_FE_TWO_BAND];

  genvar bd;
  generate
    for (bd = 0; bd < 2; bd = bd + 1) begin : g_band
      hdpc_limiter u_lim (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(lim_en[bd]),
        .sample_tick(sample_valid),
        .level(lim_level[bd*32 +: 32]),
        .threshold(lim_thr[bd*32 +: 32]),
        .attack_hold(lim_ar[bd*32+8 +: 8]),
        .release_hold(lim_ar[bd*32 +: 8]),
        .step(lim_soft[bd*32 +: 26]),
        .gain_r(lim_gain[bd*26 +: 26])
      );
    end
  endgenerate

  assign upper_band_gain = lim_gain[25:0];
  assign lower_band_gain = lim_gain[51:26];
endmodule

/* File: hdpc_partner.sv */
// far side model: strap resistor, headphone amplifier and coefficient memory
`timescale 1ns/1ns
module hdpc_partner #(
  parameter STRAP_LVL = 1'b1
) (
  input wire sys_clk,
  input wire pin_o,
  input wire pin_oe,
  output wire pin_lvl,
  output wire hp_on,
  input wire [6:0] coef_addr,
  output reg [31:0] coef_data
);
  // ==========================================
  // coefficient memory
  reg [31:0] mem [0:127];
  integer i;
  // every word differs, so a rotate-xor sum notices any single word
  initial begin
    for (i = 0; i < 128; i = i + 1) begin
      mem[i] = (32'h9E3779B9 * i) ^ 32'h5A5A0F0F;
    end
  end
  // strap resistor: pin reads the strap level whenever the block leaves it undriven
  assign pin_lvl = pin_oe ? pin_o : STRAP_LVL;
  // amplifier shutdown input is active low
  assign hp_on = pin_lvl;
  // synchronous read: word appears the cycle after the address
  always @(posedge sys_clk) begin
    coef_data <= mem[coef_addr];
  end
endmodule

/* File: hdpc_properties.sv */
// port-level checker for the headphone, fault pin and stream timing
`timescale 1ns/1ns
module hdpc_properties (
  input wire sys_clk,
  input wire rst,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire addr_select_hp_shutdown_pin_o_r,
  input wire addr_select_hp_shutdown_pin_oe_r,
  input wire overcurrent_i,
  input wire overtemp_i,
  input wire undervoltage_i,
  input wire [7:0] spk_volume,
  input wire [7:0] hp_gain_r,
  input wire pwm_run_r,
  input wire spk_mute_r,
  input wire hp_pwm_en_r,
  input wire sample_valid,
  input wire sample_out_valid_r
);
  // ==========================================
  // shadow of the second system control register
  reg [7:0] sc2_r;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sc2_r <= 8'h40;
    end else if (reg_wr && reg_addr == 8'h05) begin
      sc2_r <= reg_wdata[7:0];
    end
  end
  wire pin = addr_select_hp_shutdown_pin_o_r;
  wire oe = addr_select_hp_shutdown_pin_oe_r;
  wire hp_sd = sc2_r[4] && sc2_r[0];
  wire flt = overcurrent_i || overtemp_i || undervoltage_i;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // assertions
  oe_cause_a: assert property ($rose(oe) |-> sc2_r[1])
    else $error("pin drive enabled without the enable bit");
  pin_input_a: assert property ((!sc2_r[1])[*2] |-> !oe)
    else $error("pin driven while it should be an input");
  mute_hp_a: assert property (hp_pwm_en_r |-> spk_mute_r)
    else $error("speaker not muted in headphone mode");
  fault_low_a: assert property ((oe && !sc2_r[0] && flt)[*4] |-> !pin)
    else $error("fault pin high during a fault");
  fault_high_a: assert property ((oe && !sc2_r[0] && !flt)[*4] |-> pin)
    else $error("fault pin low without a fault");
  hp_gain_a: assert property ((!sc2_r[3])[*2] |=> hp_gain_r == $past(spk_volume))
    else $error("headphone gain not following speaker volume");
  pwm_first_a: assert property ($rose(pin) && hp_sd |-> pwm_run_r)
    else $error("shutdown released before pwm runs");
  pin_first_a: assert property ($fell(pwm_run_r) && hp_sd |-> !pin)
    else $error("pwm stopped before shutdown asserted");
  shut_pin_a: assert property ($rose(sc2_r[6]) && hp_sd |-> ##[1:2] !pin)
    else $error("shutdown pin late on entering shutdown");
  out_valid_a: assert property (sample_valid |=> sample_out_valid_r)
    else $error("processed sample missing");
endmodule

bind hdpc_top hdpc_properties i_hdpc_properties (
  .sys_clk(sys_clk),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .addr_select_hp_shutdown_pin_o_r(addr_select_hp_shutdown_pin_o_r),
  .addr_select_hp_shutdown_pin_oe_r(addr_select_hp_shutdown_pin_oe_r),
  .overcurrent_i(overcurrent_i),
  .overtemp_i(overtemp_i),
  .undervoltage_i(undervoltage_i),
  .spk_volume(spk_volume),
  .hp_gain_r(hp_gain_r),
  .pwm_run_r(pwm_run_r),
  .spk_mute_r(spk_mute_r),
  .hp_pwm_en_r(hp_pwm_en_r),
  .sample_valid(sample_valid),
  .sample_out_valid_r(sample_out_valid_r)
);

/* File: hdpc_top_test.sv */
// self-checking bench for the protection and headphone control block
`timescale 1ns/1ns
`include "hdpc_map.vh"
module hdpc_top_test;
  localparam [25:0] UNITY = `HDPC_UNITY_GAIN;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h00000000;
  reg oc = 1'b0;
  reg ot = 1'b0;
  reg uv = 1'b0;
  reg [7:0] spk_volume = 8'h33;
  reg smp_v = 1'b0;
  reg [23:0] smp_l = 24'h000000;
  reg [23:0] smp_r = 24'h000000;
  reg dtick = 1'b0;
  reg [7:0] duty = 8'h00;
  reg [31:0] lvl_hi = 32'h00000000;
  reg [31:0] lvl_lo = 32'h00000000;
  wire [31:0] rdata;
  wire rvalid, pin_i, pin_o, pin_oe, asel, pwm_run, spk_mute, hp_pwm_en, so_v;
  wire [7:0] hp_gain;
  wire [23:0] so_l, so_r;
  wire [25:0] g_hi, g_lo;
  wire [6:0] caddr;
  wire [31:0] cdata;
  integer mismatches, n_checks, i;
  reg [31:0] acc;
  // 125 MHz
  always #4 sys_clk = ~sys_clk;
  hdpc_top #(.SETTLE_CYC(8)) i_hdpc_top (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(rdata),
    .reg_rvalid_r(rvalid), .addr_select_hp_shutdown_pin_i(pin_i),
    .addr_select_hp_shutdown_pin_o_r(pin_o), .addr_select_hp_shutdown_pin_oe_r(pin_oe),
    .addr_select_r(asel), .overcurrent_i(oc), .overtemp_i(ot), .undervoltage_i(uv),
    .spk_volume(spk_volume), .hp_gain_r(hp_gain), .pwm_run_r(pwm_run),
    .spk_mute_r(spk_mute), .hp_pwm_en_r(hp_pwm_en), .sample_valid(smp_v),
    .sample_l(smp_l), .sample_r(smp_r), .sample_out_valid_r(so_v), .sample_out_l_r(so_l),
    .sample_out_r_r(so_r), .duty_tick(dtick), .duty(duty), .band_hi_level(lvl_hi),
    .band_lo_level(lvl_lo), .upper_band_gain(g_hi), .lower_band_gain(g_lo),
    .coef_rd_addr_r(caddr), .coef_rd_data(cdata));
  hdpc_partner #(.STRAP_LVL(1'b1)) i_hdpc_partner (.sys_clk(sys_clk), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_lvl(pin_i),
    .hp_on(), .coef_addr(caddr), .coef_data(cdata));
  // ==========================================
  // shared tasks
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        mismatches = mismatches + 1;
      end
    end
  endtask
  // sample a little after the edge so its updates have landed
  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] exp);
    begin
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(rvalid, 1'b1);
      chk(rdata, exp);
    end
  endtask
  task smp(input [23:0] l, input [23:0] r);
    begin
      @(posedge sys_clk);
      smp_v <= 1'b1;
      smp_l <= l;
      smp_r <= r;
      @(posedge sys_clk);
      smp_v <= 1'b0;
      #1;
    end
  endtask
  task tick(input [7:0] d);
    begin
      @(posedge sys_clk);
      dtick <= 1'b1;
      duty <= d;
      @(posedge sys_clk);
      dtick <= 1'b0;
    end
  endtask
  // set both band energies, then run n limiter samples
  task lvl(input [31:0] hi, input [31:0] lo, input integer n);
    begin
      @(posedge sys_clk);
      lvl_hi <= hi;
      lvl_lo <= lo;
      repeat (n) smp(24'h000000, 24'h000000);
    end
  endtask
  task wrap_up;
    begin
      $display("Comparisons %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    begin
      chk(pin_oe, 1'b0);
      chk(asel, 1'b1);
      chk(spk_mute, 1'b1);
      rchk(`HDPC_OFF_SYSCTL2, 32'h00000040);
      rchk(`HDPC_OFF_CLIP, `HDPC_RST_CLIP);
      rchk(`HDPC_OFF_SCALE, `HDPC_RST_SCALE);
      wr(`HDPC_OFF_ERROR, 32'h000000FF);
      rchk(`HDPC_OFF_ERROR, 32'h00000000);
      rchk(8'h7E, 32'h00000000);
    end
  endtask
  task t_hp;
    begin
      wr(`HDPC_OFF_HP_VOL, 32'h0000005C);
      wr(`HDPC_OFF_SYSCTL2, 32'h00000013);
      cyc(3);
      chk(pwm_run, 1'b1);
      chk(pin_o, 1'b0);
      chk(spk_mute, 1'b1);
      chk(hp_pwm_en, 1'b1);
      chk(hp_gain, 8'h33);
      cyc(12);
      chk(pin_i, 1'b1);
      wr(`HDPC_OFF_SYSCTL2, 32'h0000001B);
      cyc(3);
      chk(hp_gain, 8'h5C);
      wr(`HDPC_OFF_SYSCTL2, 32'h0000005B);
      cyc(2);
      chk(pin_o, 1'b0);
      chk(pwm_run, 1'b1);
      cyc(12);
      chk(pwm_run, 1'b0);
    end
  endtask
  // each fault source in turn must pull the pin low
  task t_fault;
    begin
      wr(`HDPC_OFF_SYSCTL2, 32'h00000002);
      cyc(12);
      chk(spk_mute, 1'b0);
      chk(pin_o, 1'b1);
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge sys_clk);
        {uv, ot, oc} <= 3'b001 << i;
        cyc(5);
        chk(pin_i, 1'b0);
        @(posedge sys_clk);
        {uv, ot, oc} <= 3'b000;
        cyc(5);
        chk(pin_o, 1'b1);
      end
    end
  endtask
  task t_clip;
    begin
      wr(`HDPC_OFF_CLIP, 32'h00100000);
      wr(`HDPC_OFF_SCALE, 32'h00400000);
      smp(24'h200000, 24'hE00000);
      chk(so_v, 1'b1);
      chk(so_l, 24'h080000);
      chk(so_r, 24'hF80000);
      smp(24'h040000, 24'hFC0000);
      chk(so_l, 24'h020000);
      chk(so_r, 24'hFE0000);
    end
  endtask
  // threshold 3, duration 2: flag appears on the third tick over
  task t_dc;
    begin
      wr(`HDPC_OFF_DC_CFG, 32'h00000032);
      repeat (4) tick(8'h50);
      rchk(`HDPC_OFF_ERROR, 32'h00000000);
      wr(`HDPC_OFF_FEATURE, 32'h00000400);
      repeat (2) tick(8'h50);
      rchk(`HDPC_OFF_ERROR, 32'h00000000);
      tick(8'h50);
      rchk(`HDPC_OFF_ERROR, 32'h00000001);
      tick(8'h30);
      rchk(`HDPC_OFF_ERROR, 32'h00000000);
      repeat (3) tick(8'h50);
      wr(`HDPC_OFF_FEATURE, 32'h00000000);
      rchk(`HDPC_OFF_ERROR, 32'h00000000);
    end
  endtask
  task t_crc;
    begin
      acc = 32'h00000000;
      for (i = 0; i < 80; i = i + 1) begin
        acc = {acc[30:0], acc[31]} ^ i_hdpc_partner.mem[i];
      end
      wr(`HDPC_OFF_CHKSUM, acc);
      wr(`HDPC_OFF_FEATURE, 32'h02000000);
      cyc(600);
      rchk(`HDPC_OFF_ERROR, 32'h00000000);
      wr(`HDPC_OFF_CHKSUM, acc ^ 32'h00000001);
      cyc(600);
      rchk(`HDPC_OFF_ERROR, 32'h00000008);
      wr(`HDPC_OFF_FEATURE, 32'h00000000);
    end
  endtask
  // hold of two samples, small step so gains never reach zero
  task t_lim;
    begin
      wr(`HDPC_OFF_SYSCTL2, 32'h00000040);
      wr(`HDPC_OFF_L1_AR, 32'h00000202);
      wr(`HDPC_OFF_L2_AR, 32'h00000202);
      wr(`HDPC_OFF_L1_SOFT, 32'h00010000);
      wr(`HDPC_OFF_L2_SOFT, 32'h00010000);
      wr(`HDPC_OFF_L1_THR, 32'h01000000);
      wr(`HDPC_OFF_L2_THR, 32'h01000000);
      wr(`HDPC_OFF_FEATURE, 32'h00000003);
      lvl(32'h02000000, 32'h00800000, 1);
      chk(g_hi, UNITY);
      lvl(32'h02000000, 32'h00800000, 6);
      chk(g_hi < UNITY, 1'b1);
      chk(g_lo, UNITY);
      lvl(32'h00800000, 32'h02000000, 30);
      chk(g_hi, UNITY);
      chk(g_lo < UNITY, 1'b1);
      lvl(32'h00800000, 32'h00800000, 30);
      chk(g_lo, UNITY);
      wr(`HDPC_OFF_FEATURE, 32'h00000001);
      lvl(32'h00800000, 32'h02000000, 8);
      chk(g_lo, UNITY);
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    mismatches = 0;
    n_checks = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(2);
    t_reset;
    t_hp;
    t_fault;
    t_clip;
    t_dc;
    t_crc;
    t_lim;
    wrap_up;
  end
  // the run needs about 1550 cycles, so this only fires on a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches = mismatches + 1;
    wrap_up;
  end
endmodule
